// File: verilog/rcp_ctrl.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module rcp_ctrl
   import rcp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_reset_in_n,
   input wire logic main_osc_in,
   input wire logic ext_clock_input,
   input wire logic rtc_osc_in,
   input wire logic osc_stable_in,
   input wire logic pll_lock_in,
   input wire logic wake_in,
   output logic sys_reset_out_n,
   output logic main_osc_en,
   output logic pll_en,
   output logic clk_src_ext,
   output logic cpu_clk_gate,
   output logic [N_PERIPH-1:0] periph_clk_gate,
   output logic hclk_tick,
   output logic pclk_tick,
   output logic serial_port_ref_tick,
   output logic [1:0] pwm_tick,
   output logic rtc_1hz_tick
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [6:0] sync1, sync2;
   logic [2:0] clk_prev;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // reset pin starts at its idle level, so no false reset follows
         sync1 <= SYNC_RST;
         sync2 <= SYNC_RST;
         clk_prev <= '0;
      end
      else
      begin
         sync1 <= {ext_reset_in_n, main_osc_in, ext_clock_input, rtc_osc_in,
                   osc_stable_in, pll_lock_in, wake_in};
         sync2 <= sync1;
         clk_prev <= sync2[5:3];
      end
   end

   wire logic ext_low = !sync2[6];
   wire logic osc_edge = sync2[5] && !clk_prev[2];
   wire logic ext_edge = sync2[4] && !clk_prev[1];
   wire logic rtc_edge = sync2[3] && !clk_prev[0];
   wire logic wake = sync2[0];

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0] mode_req;
   logic ser_src_ext;
   logic [8:0] clk_en;
   logic [PRE_W-1:0] div_reg [4];
   rcp_pm_type pm_state, next_pm;
   rcp_rs_type rs_state, next_rs;
   logic [CNT_W-1:0] rs_cnt;
   logic [RTC_W-1:0] rtc_cnt;
   logic periph_run;
   logic [3:0] pre_tick;

   // oscillator and pll are not waited on when the external clock is used
   wire logic osc_ok = sync2[2] || clk_src_ext;
   wire logic pll_ok = sync2[1] || clk_src_ext;
   wire logic lock_ready = osc_ok && pll_ok;

   wire logic apb_setup = psel && !penable;
   wire logic apb_wr = psel && penable && pwrite;
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_clk_en = (paddr == ADDR_CLK_EN);
   wire logic hit_status = (paddr == ADDR_STATUS);
   wire logic [2:0] div_idx = 3'(paddr[4:2] - 3'd2);
   wire logic hit_div = (paddr[7:5] == 3'b000) && (paddr[1:0] == 2'b00)
                        && (paddr[4:2] >= 3'd2) && (paddr[4:2] <= 3'd5);
   wire logic mapped = hit_ctrl || hit_clk_en || hit_status || hit_div;
   wire logic [2:0] wr_mode = pwdata[CTRL_MODE_LSB +: 3];
   wire logic mode_legal = (wr_mode <= 3'(PM_STOP_ALL_OFF));
   wire logic sw_rst = apb_wr && hit_ctrl && pwdata[CTRL_SWRST_BIT];
   wire logic low_mode = (pm_state == PM_STANDBY) || (pm_state == PM_SLEEP)
                         || (pm_state == PM_STOP_OSC_ON) || (pm_state == PM_STOP_ALL_OFF);
   wire logic wake_go = wake && low_mode;

   wire logic [31:0] ctrl_rd = 32'({ser_src_ext, clk_src_ext, mode_req});
   wire logic [31:0] status_rd = 32'({lock_ready, sys_reset_out_n, rs_state, pm_state});
   wire logic [31:0] div_rd = hit_div ? 32'(div_reg[div_idx[1:0]]) : 32'h0;
   wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd
                            : hit_clk_en ? 32'(clk_en)
                            : hit_status ? status_rd
                            : div_rd;

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         prdata <= '0;
      else if (apb_setup)
         prdata <= mapped ? rd_mux : 32'h0;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_req <= 3'(PM_ACTIVE);
         clk_src_ext <= 1'b0;
         ser_src_ext <= 1'b0;
      end
      else if (apb_wr && hit_ctrl)
      begin
         if (mode_legal)
            mode_req <= wr_mode;
         clk_src_ext <= pwdata[CTRL_EXT_BIT];
         ser_src_ext <= pwdata[CTRL_SER_SRC_BIT];
      end
      else if (wake_go || rs_state == RS_HELD)
         mode_req <= 3'(PM_ACTIVE);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         clk_en <= CLK_EN_RST;
      else if (apb_wr && hit_clk_en)
         clk_en <= pwdata[8:0];
   end

   // divisors: 0 hclk, 1 serial, 2 pwm0, 3 pwm1
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_div
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               div_reg[g] <= DIV_RST;
            else if (apb_wr && hit_div && div_idx[1:0] == 2'(g))
               div_reg[g] <= pwdata[PRE_W-1:0];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // clock rate generation
   // ------------------------------------------------------------
   // pll output is mclk itself, so its base rate ticks every cycle
   wire logic hclk_src = clk_src_ext ? ext_edge : 1'b1;
   wire logic ser_src = ser_src_ext ? ext_edge : osc_edge;
   wire logic [3:0] pre_src = {pre_tick[0], pre_tick[0], ser_src, hclk_src};

   generate
      for (g = 0; g < 4; g++)
      begin : g_pre
         rcp_prescale u_pre (
            .mclk(mclk),
            .rst_b(rst_b),
            .src_tick(pre_src[g]),
            .div(div_reg[g]),
            .tick(pre_tick[g])
         );
      end
   endgenerate

   assign hclk_tick = pre_tick[0];
   // same enable as hclk, so the peripheral bus can never drift in phase
   assign pclk_tick = pre_tick[0] && periph_run;
   assign serial_port_ref_tick = pre_tick[1] && periph_run;
   assign pwm_tick = pre_tick[3:2] & {2{periph_run}};

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rtc_cnt <= '0;
         rtc_1hz_tick <= 1'b0;
      end
      else
      begin
         rtc_1hz_tick <= rtc_edge && rtc_cnt == RTC_W'(RTC_DIV - 1);
         if (rtc_edge)
            rtc_cnt <= rtc_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // power mode sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      next_pm = pm_state;
      unique case (pm_state)
         PM_ACTIVE:
            if (mode_req != 3'(PM_ACTIVE)) next_pm = rcp_pm_type'(mode_req);
         PM_STANDBY, PM_SLEEP:
            if (wake) next_pm = PM_ACTIVE;
         PM_STOP_OSC_ON:
            if (wake) next_pm = PM_WAKE_PLL;
         PM_STOP_ALL_OFF:
            if (wake) next_pm = PM_WAKE_OSC;
         PM_WAKE_OSC:
            if (osc_ok) next_pm = PM_WAKE_PLL;
         PM_WAKE_PLL:
            if (pll_ok) next_pm = PM_ACTIVE;
         default:
            next_pm = PM_WAKE_OSC;
      endcase
      // hard reset restarts every state except PM_ACTIVE the slow way, through PM_WAKE_OSC
      if (rs_state == RS_HELD && pm_state != PM_ACTIVE)
         next_pm = PM_WAKE_OSC;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pm_state <= PM_ACTIVE;
         main_osc_en <= 1'b1;
         pll_en <= 1'b1;
         periph_run <= 1'b1;
         cpu_clk_gate <= 1'b1;
      end
      else
      begin
         pm_state <= next_pm;
         main_osc_en <= !clk_src_ext && pm_state != PM_STOP_ALL_OFF;
         pll_en <= !clk_src_ext && pm_state != PM_STOP_ALL_OFF
                   && pm_state != PM_STOP_OSC_ON
                   && pm_state != PM_WAKE_OSC;
         periph_run <= pm_state == PM_ACTIVE || pm_state == PM_STANDBY;
         cpu_clk_gate <= pm_state == PM_ACTIVE && clk_en[CLK_EN_CPU_BIT];
      end
   end

   generate
      for (g = 0; g < N_PERIPH; g++)
      begin : g_gate
         assign periph_clk_gate[g] = periph_run && clk_en[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // reset sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      next_rs = rs_state;
      unique case (rs_state)
         RS_RUN:
            if (ext_low) next_rs = RS_DELAY;
            else if (sw_rst) next_rs = RS_LOCK;
         RS_DELAY:
            if (rs_cnt == CNT_W'(RST_ASSERT_CYC - 1)) next_rs = RS_HELD;
         RS_HELD:
            if (!ext_low) next_rs = RS_LOCK;
         RS_LOCK:
            if (ext_low) next_rs = RS_HELD;
            else if (lock_ready || rs_cnt == CNT_W'(PLL_LOCK_CYC - 1))
               next_rs = RS_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rs_state <= RS_LOCK;
         rs_cnt <= '0;
         sys_reset_out_n <= 1'b0;
      end
      else
      begin
         rs_state <= next_rs;
         rs_cnt <= (next_rs != rs_state) ? '0 : rs_cnt + 1'b1;
         sys_reset_out_n <= next_rs == RS_RUN || next_rs == RS_DELAY;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_assert_delay;
      (rs_state == RS_RUN && ext_low)
         |-> sys_reset_out_n [*4] ##1 !sys_reset_out_n;
   endproperty
   a_assert_delay: assert property (p_assert_delay) else $error("reset output late");
   property p_release;
      (rs_state == RS_HELD && !ext_low && lock_ready) ##1 lock_ready |-> ##1 sys_reset_out_n;
   endproperty
   a_release: assert property (p_release) else $error("reset output released late");
   property p_lock_bound;
      rs_state == RS_LOCK |-> rs_cnt < CNT_W'(PLL_LOCK_CYC);
   endproperty
   a_lock_bound: assert property (p_lock_bound) else $error("lock wait too long");
   property p_standby;
      (pm_state == PM_STANDBY && !clk_src_ext) |=>
         !cpu_clk_gate && pll_en && main_osc_en && periph_run;
   endproperty
   a_standby: assert property (p_standby) else $error("standby clock states wrong");
   property p_stop_all;
      pm_state == PM_STOP_ALL_OFF |=>
         !main_osc_en && !pll_en && periph_clk_gate == '0 && !cpu_clk_gate;
   endproperty
   a_stop_all: assert property (p_stop_all) else $error("stop clocks not off");
   property p_wake_gated;
      pm_state == PM_WAKE_OSC |=> !periph_run && !cpu_clk_gate;
   endproperty
   a_wake_gated: assert property (p_wake_gated) else $error("clocks before stable");
   property p_mode_legal;
      (apb_wr && hit_ctrl && !mode_legal) |=> $stable(mode_req);
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("bad mode taken");
   property p_swrst;
      (sw_rst && rs_state == RS_RUN && !ext_low) |=> !sys_reset_out_n;
   endproperty
   a_swrst: assert property (p_swrst) else $error("software reset ignored");
   property p_rtc;
      rtc_1hz_tick |-> rtc_cnt == '0 && $past(rtc_cnt) == RTC_W'(RTC_DIV - 1);
   endproperty
   a_rtc: assert property (p_rtc) else $error("rtc tick at wrong count");
   property p_pclk;
      pclk_tick == (hclk_tick && ($past(pm_state) == PM_ACTIVE
                                  || $past(pm_state) == PM_STANDBY));
   endproperty
   a_pclk: assert property (p_pclk) else $error("peripheral clock off bus clock");

   c_stop_wake: cover property (pm_state == PM_WAKE_PLL ##1 pm_state == PM_ACTIVE);
   c_ext_reset: cover property (rs_state == RS_HELD ##1 rs_state == RS_LOCK);
   c_rtc: cover property (rtc_1hz_tick);
   c_sleep: cover property (pm_state == PM_SLEEP);

endmodule // rcp_ctrl
`default_nettype wire

// File: verilog/rcp_pkg.sv
`default_nettype none
package rcp_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned PLL_LOCK_MAX_NS = 10000;
   // longest time, rounds down
   localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned RST_ASSERT_CYC = 3;
   localparam int unsigned RTC_OSC_HZ = 32768;
   localparam int unsigned RTC_TICK_HZ = 1;
   localparam int unsigned RTC_DIV = RTC_OSC_HZ / RTC_TICK_HZ;
   localparam int unsigned CNT_W = 12;
   localparam int unsigned RTC_W = 15;
   localparam int unsigned PRE_W = 8;
   localparam int unsigned N_PERIPH = 8;
   localparam logic [6:0] SYNC_RST = 7'h40;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLK_EN = 8'h04;
   localparam logic [7:0] ADDR_HCLK_DIV = 8'h08;
   localparam logic [7:0] ADDR_SER_DIV = 8'h0c;
   localparam logic [7:0] ADDR_PWM0_DIV = 8'h10;
   localparam logic [7:0] ADDR_PWM1_DIV = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_EXT_BIT = 3;
   localparam int unsigned CTRL_SER_SRC_BIT = 4;
   localparam int unsigned CTRL_SWRST_BIT = 5;
   localparam int unsigned CLK_EN_CPU_BIT = 8;

   localparam logic [8:0] CLK_EN_RST = 9'h1ff;
   localparam logic [7:0] DIV_RST = 8'h00;

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PM_ACTIVE = 3'b000,
      PM_STANDBY = 3'b001,
      PM_SLEEP = 3'b010,
      PM_STOP_OSC_ON = 3'b011,
      PM_STOP_ALL_OFF = 3'b100,
      PM_WAKE_OSC = 3'b101,
      PM_WAKE_PLL = 3'b110
   } rcp_pm_type;

   typedef enum logic [1:0] {
      RS_RUN = 2'b00,
      RS_DELAY = 2'b01,
      RS_HELD = 2'b10,
      RS_LOCK = 2'b11
   } rcp_rs_type;

endpackage
`default_nettype wire

// File: verilog/rcp_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module rcp_prescale
   import rcp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic src_tick,
   input wire logic [PRE_W-1:0] div,
   output logic tick
);

   logic [PRE_W-1:0] cnt;
   // >= so a smaller divisor written mid-count wraps at once
   wire logic wrap = (cnt >= div);

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= src_tick && wrap;
         if (src_tick)
            cnt <= wrap ? '0 : cnt + 1'b1;
      end
   end

endmodule // rcp_prescale
`default_nettype wire

// File: tb/rcp_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcp_partner_model
#(
   parameter int OSC_DLY = 20,
   parameter int PLL_DLY = 10
)
(
   input wire logic mclk,
   input wire logic main_osc_en,
   input wire logic pll_en,
   input wire logic pulse_go,
   input wire logic [7:0] pulse_len,
   output logic ext_reset_in_n,
   output logic main_osc_in,
   output logic ext_clock_input,
   output logic rtc_osc_in,
   output logic osc_stable_in,
   output logic pll_lock_in
);
   int osc_cnt, pll_cnt, rst_cnt, ext_cnt, osc_div, next_rst;

   initial
   begin
      {ext_reset_in_n, main_osc_in, ext_clock_input, rtc_osc_in} = 4'h8;
      {osc_stable_in, pll_lock_in} = 2'b00;
      {osc_cnt, pll_cnt, rst_cnt, ext_cnt, osc_div} = '0;
   end

   // --------------------------------------------------------
   // oscillators: a stopped oscillator shows no edges
   // --------------------------------------------------------
   always @(posedge mclk)
   begin
      rtc_osc_in <= ~rtc_osc_in;
      ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
      if (ext_cnt == 2)
         ext_clock_input <= ~ext_clock_input;
      osc_div <= osc_div + 1;
      main_osc_in <= main_osc_en & osc_div[1];
      osc_cnt <= main_osc_en ? ((osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt) : 0;
      osc_stable_in <= main_osc_en && osc_cnt >= OSC_DLY;
      pll_cnt <= (pll_en && osc_stable_in) ? ((pll_cnt < PLL_DLY) ? pll_cnt + 1 : pll_cnt) : 0;
      pll_lock_in <= pll_en && pll_cnt >= PLL_DLY;
   end

   // --------------------------------------------------------
   // reset source
   // --------------------------------------------------------
   always @(posedge mclk)
   begin
      next_rst = pulse_go ? ((pulse_len < 2) ? 2 : int'(pulse_len)) :
         ((rst_cnt != 0) ? rst_cnt - 1 : 0);
      rst_cnt <= next_rst;
      ext_reset_in_n <= (next_rst == 0);
   end
endmodule // rcp_partner_model
`default_nettype wire

// File: tb/test_reset_clock_power_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_reset_clock_power_ctrl
   import rcp_pkg::*;
;
   localparam int S_RST = 0, S_CPU = 1, S_PCLK = 2, S_HCLK = 3, S_SER = 4;
   localparam int S_PWM0 = 5, S_PWM1 = 6, S_RTC = 7, S_PIN = 8;
   logic mclk, rst_b, psel, penable, pwrite, wake_in, pulse_go, rtc_done;
   logic [7:0] paddr, pulse_len;
   logic [31:0] pwdata, prdata, lfsr_state;
   logic pready, pslverr, ext_reset_in_n, main_osc_in, ext_clock_input, rtc_osc_in;
   logic osc_stable_in, pll_lock_in, sys_reset_out_n, main_osc_en, pll_en, clk_src_ext;
   logic cpu_clk_gate, hclk_tick, pclk_tick, serial_port_ref_tick, rtc_1hz_tick;
   logic [N_PERIPH-1:0] periph_clk_gate;
   logic [1:0] pwm_tick;
   logic [3:0] g;
   logic [39:0] exp_q[$];
   int num_errors, checks, n, d;
   wire logic [8:0] obs = {ext_reset_in_n, rtc_1hz_tick, pwm_tick, serial_port_ref_tick,
      hclk_tick, pclk_tick, cpu_clk_gate, sys_reset_out_n};

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   rcp_ctrl u_rcp_ctrl (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_reset_in_n(ext_reset_in_n), .main_osc_in(main_osc_in),
      .ext_clock_input(ext_clock_input), .rtc_osc_in(rtc_osc_in),
      .osc_stable_in(osc_stable_in), .pll_lock_in(pll_lock_in), .wake_in(wake_in),
      .sys_reset_out_n(sys_reset_out_n), .main_osc_en(main_osc_en), .pll_en(pll_en),
      .clk_src_ext(clk_src_ext), .cpu_clk_gate(cpu_clk_gate),
      .periph_clk_gate(periph_clk_gate), .hclk_tick(hclk_tick), .pclk_tick(pclk_tick),
      .serial_port_ref_tick(serial_port_ref_tick), .pwm_tick(pwm_tick),
      .rtc_1hz_tick(rtc_1hz_tick));

   rcp_partner_model u_rcp_partner_model (.mclk(mclk), .main_osc_en(main_osc_en),
      .pll_en(pll_en), .pulse_go(pulse_go), .pulse_len(pulse_len),
      .ext_reset_in_n(ext_reset_in_n), .main_osc_in(main_osc_in),
      .ext_clock_input(ext_clock_input), .rtc_osc_in(rtc_osc_in),
      .osc_stable_in(osc_stable_in), .pll_lock_in(pll_lock_in));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // {osc, pll, peripheral, cpu} per mode
   function automatic logic [3:0] mode_gates(input int m);
      case (m)
         0: return 4'b1111;
         1: return 4'b1110;
         2: return 4'b1100;
         3: return 4'b1000;
         default: return 4'b0000;
      endcase
   endfunction

   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // --------------------------------------------------------
   // apb master
   // --------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // only the watchdog ends a wait that never gets an answer
      while (pready !== 1'b1)
         @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      exp_q.push_back({7'h0, err, e});
      apb(1'b0, a, 32'h0);
   endtask

   always @(posedge mclk)
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
         check({7'h0, pslverr, prdata}, (exp_q.size() > 0) ? exp_q.pop_front() : '1);

   // settled sampling, a little after the edge
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic wait_for(input int sel, input logic v, input int max, output int cnt);
      cnt = 0;
      do
      begin
         tick();
         cnt++;
      end
      while (obs[sel] !== v && cnt < max);
      if (obs[sel] !== v)
      begin
         num_errors++;
         $display("mismatch at %0t: wait ran out on %0d", $time, sel);
      end
   endtask

   task automatic interval(input int sel, input int want);
      int cnt;
      wait_for(sel, 1'b1, 2000, cnt);
      wait_for(sel, 1'b1, 2000, cnt);
      check(cnt, want);
   endtask

   // rtc divider watched from reset release
   initial
   begin
      int e;
      logic last;
      rtc_done = 1'b0;
      @(posedge rst_b);
      e = 0;
      last = 1'b0;
      while (rtc_1hz_tick !== 1'b1 && e < 40000)
      begin
         tick();
         if (rtc_osc_in && !last)
            e++;
         last = rtc_osc_in;
      end
      check(e >= RTC_DIV - 2 && e <= RTC_DIV + 4, 1'b1);
      rtc_done = 1'b1;
   end

   initial
   begin
      #(4 * 90000);
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      {rst_b, psel, penable, pwrite, wake_in, pulse_go} = '0;
      {paddr, pulse_len, pwdata} = '0;
      {num_errors, checks} = '0;
      lfsr_state = 32'h4769473c;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      wait_for(S_RST, 1'b1, 2600, n);
      check(n < 80, 1'b1);
      rd(ADDR_STATUS, 32'h60, 1'b0);
      rd(ADDR_CLK_EN, {23'h0, CLK_EN_RST}, 1'b0);
      rd(ADDR_CTRL, 32'h0, 1'b0);
      rd(8'h1c, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         lfsr_state = lfsr_next(lfsr_state);
         apb(1'b1, ADDR_CLK_EN, {23'h0, lfsr_state[8:0]});
         repeat (2) tick();
         check({cpu_clk_gate, periph_clk_gate}, lfsr_state[8:0]);
      end
      apb(1'b1, ADDR_CLK_EN, 32'h1ff);
      for (int m = 1; m <= 4; m++)
      begin
         apb(1'b1, ADDR_CTRL, m);
         repeat (3) tick();
         g = mode_gates(m);
         check({main_osc_en, pll_en, cpu_clk_gate, periph_clk_gate},
            {g[3], g[2], g[0], {8{g[1]}}});
         @(posedge mclk);
         wake_in <= 1'b1;
         wait_for(S_CPU, 1'b1, 500, n);
         check({osc_stable_in, pll_lock_in, main_osc_en, pll_en}, 4'hf);
         @(posedge mclk);
         wake_in <= 1'b0;
         rd(ADDR_CTRL, 32'h0, 1'b0);
      end
      apb(1'b1, ADDR_CTRL, 32'h5);
      repeat (3) tick();
      check(cpu_clk_gate, 1'b1);
      rd(ADDR_CTRL, 32'h0, 1'b0);
      apb(1'b1, ADDR_HCLK_DIV, 32'h0);
      interval(S_HCLK, 1);
      interval(S_PCLK, 1);
      apb(1'b1, ADDR_HCLK_DIV, 32'h1);
      interval(S_HCLK, 2);
      interval(S_PCLK, 2);
      lfsr_state = lfsr_next(lfsr_state);
      d = lfsr_state[2:0];
      apb(1'b1, ADDR_PWM0_DIV, d);
      rd(ADDR_PWM0_DIV, d, 1'b0);
      interval(S_PWM0, 2 * (d + 1));
      apb(1'b1, ADDR_PWM1_DIV, 7 - d);
      interval(S_PWM1, 2 * (8 - d));
      apb(1'b1, ADDR_SER_DIV, 32'h1);
      interval(S_SER, 8);
      apb(1'b1, ADDR_CTRL, 32'h18);
      repeat (3) tick();
      check({clk_src_ext, main_osc_en, pll_en}, 3'b100);
      interval(S_HCLK, 12);
      interval(S_SER, 12);
      apb(1'b1, ADDR_CTRL, 32'h0);
      wait_for(S_CPU, 1'b1, 500, n);
      repeat (60) tick();
      @(posedge mclk);
      pulse_len <= 8'ha;
      pulse_go <= 1'b1;
      @(posedge mclk);
      pulse_go <= 1'b0;
      wait_for(S_RST, 1'b0, 20, n);
      check(n >= 5 && n <= 7, 1'b1);
      wait_for(S_PIN, 1'b1, 20, n);
      wait_for(S_RST, 1'b1, 2600, n);
      check(n >= 2 && n <= 5, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h20);
      // with the pll locked the output drops for one cycle only
      #1;
      check(sys_reset_out_n, 1'b0);
      wait_for(S_RST, 1'b1, 2600, n);
      check(n <= 2600, 1'b1);
      rd(ADDR_CTRL, 32'h0, 1'b0);
      while (rtc_done !== 1'b1)
         tick();
      report_and_stop();
   end
endmodule // test_reset_clock_power_ctrl
`default_nettype wire
